// file: src/aes_pkg.sv
// Purpose: Shared constants and types of the converter event scheduler.
// Assumes: Core clock of 10 MHz; converter runs from a divided clock enable.
// Notes: Converter timing counts are in converter clock periods.
package aes_pkg;
    // ==========================================================
    // Geometry
    localparam int NUM_SLOTS = 8;
    localparam int SLOT_W = 3;
    localparam int NUM_CH = 4;
    localparam int CH_W = 2;
    localparam int RES_W = 10;
    localparam int NUM_STATES = 8;
    localparam int STATE_W = 3;
    localparam int TMR_W = 16;
    // Channel map.
    localparam logic [1:0] CH_LINE = 2'h0;
    localparam logic [1:0] CH_OUT_FEEDBACK = 2'h1;
    // ==========================================================
    // Timing
    localparam int CLK_HZ = 10_000_000;
    localparam int ADC_DIV = 2;
    localparam int T_SAMPLE_CYC = 7;
    localparam int T_CONV_CYC = 18;
    localparam int DC_PERIOD_US = 8300;
    localparam int DC_PERIOD_CYC = (DC_PERIOD_US * (CLK_HZ / 1_000_000));
    // ==========================================================
    // Trigger sources and converter states
    typedef enum logic {AES_TRIG_STATE, AES_TRIG_TIMER} aes_trig_type;
    typedef enum logic [1:0] {AES_IDLE, AES_SAMPLE, AES_CONVERT, AES_DONE} aes_fsm_type;
endpackage

// file: src/aes_converter.sv
// Purpose: Converter sequencer that samples one channel and returns a result.
// Assumes: Analog result word is presented on i_adc_data by the analog core.
// Notes: Conversion takes a fixed number of converter clock periods.
module aes_converter (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_start,
    input wire logic [1:0] i_ch,
    input wire logic [9:0] i_adc_data,
    output logic o_busy,
    output logic o_done,
    output logic [1:0] o_ch,
    output logic [9:0] o_data,
    output logic o_sampling
);
    // ==========================================================
    // State
    aes_pkg::aes_fsm_type st_r, st_nxt;
    logic [4:0] cnt_r, cnt_nxt;
    logic div_r, div_nxt;
    logic [1:0] ch_r, ch_nxt;
    logic [9:0] data_r, data_nxt;

    // Next state: counts converter clocks through sample and convert phases.
    always_comb begin
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        div_nxt = ~div_r;
        ch_nxt = ch_r;
        data_nxt = data_r;
        unique case (st_r)
            aes_pkg::AES_IDLE: begin
                div_nxt = 1'b0;
                if (i_start) begin
                    st_nxt = aes_pkg::AES_SAMPLE;
                    cnt_nxt = 5'h00;
                    ch_nxt = i_ch;
                end
            end
            aes_pkg::AES_SAMPLE: begin
                if (div_r) begin
                    cnt_nxt = cnt_r + 5'h01;
                    if (cnt_r == 5'(aes_pkg::T_SAMPLE_CYC - 1)) begin
                        st_nxt = aes_pkg::AES_CONVERT;
                    end
                end
            end
            aes_pkg::AES_CONVERT: begin
                if (div_r) begin
                    cnt_nxt = cnt_r + 5'h01;
                    if (cnt_r == 5'(aes_pkg::T_CONV_CYC - 1)) begin
                        st_nxt = aes_pkg::AES_DONE;
                        data_nxt = i_adc_data;
                    end
                end
            end
            aes_pkg::AES_DONE: begin
                st_nxt = aes_pkg::AES_IDLE;
            end
        endcase
    end

    // Registers.
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            st_r <= aes_pkg::AES_IDLE;
            cnt_r <= 5'h00;
            div_r <= 1'b0;
            ch_r <= 2'h0;
            data_r <= 10'h000;
        end else begin
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            div_r <= div_nxt;
            ch_r <= ch_nxt;
            data_r <= data_nxt;
        end
    end

    // Outputs.
    assign o_busy = (st_r != aes_pkg::AES_IDLE);
    assign o_done = (st_r == aes_pkg::AES_DONE);
    assign o_sampling = (st_r == aes_pkg::AES_SAMPLE);
    assign o_ch = ch_r;
    assign o_data = data_r;
endmodule

// file: src/aes_scheduler.sv
// Purpose: Event driven scheduler for the multichannel converter.
// Assumes: Triggers and configuration come from logic on the same clock.
// Notes: Configuration is held on plain ports; no software register bus.
module aes_scheduler (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_enable,
    input wire logic [2:0] i_seq_len_m1,
    input wire logic [15:0] i_slot_ch,
    input wire logic [7:0] i_slot_trig_timer,
    input wire logic [23:0] i_slot_state,
    input wire logic [127:0] i_slot_tmr_val,
    input wire logic [7:0] i_slot_high_prio,
    input wire logic [7:0] i_slot_irq_en,
    input wire logic [2:0] i_event_state_machine,
    input wire logic [15:0] i_timer,
    input wire logic i_line_peak,
    input wire logic i_dc_start,
    input wire logic [9:0] i_adc_data,
    input wire logic [1:0] i_rd_ch,
    output logic [9:0] o_rd_data,
    output logic [39:0] o_results,
    output logic o_irq,
    output logic o_busy,
    output logic o_adc_sampling,
    output logic [1:0] o_adc_ch
);
    // ==========================================================
    // Declarations
    logic [7:0] pend_r, pend_nxt;
    logic [2:0] seq_r, seq_nxt;
    logic [2:0] state_q_r, state_q_nxt;
    logic [2:0] act_slot_r, act_slot_nxt;
    logic [31:0] dc_cnt_r, dc_cnt_nxt;
    logic line_req_r, line_req_nxt;
    logic line_act_r, line_act_nxt;
    logic irq_r, irq_nxt;
    logic [9:0] res_r [aes_pkg::NUM_CH];
    logic [9:0] res_nxt [aes_pkg::NUM_CH];
    logic [7:0] fire;
    logic conv_start, conv_busy, conv_done;
    logic [1:0] conv_ch, start_ch, done_ch;
    logic [9:0] conv_data;
    logic [2:0] pick_slot;
    logic pick_ok;

    // Slot channel lookup used by issue; completion takes the channel from the converter.
    function automatic logic [1:0] slot_ch(input logic [15:0] v, input logic [2:0] s);
        slot_ch = v[s*2 +: 2];
    endfunction

    // ==========================================================
    // Trigger detection: state entry edge or timer match per slot.
    for (genvar g = 0; g < aes_pkg::NUM_SLOTS; g++) begin : g_trig
        logic in_seq, st_hit, tm_hit;
        assign in_seq = (3'(g) <= i_seq_len_m1);
        assign st_hit = (i_event_state_machine == i_slot_state[g*3 +: 3]) &&
                        (state_q_r != i_slot_state[g*3 +: 3]);
        assign tm_hit = (i_timer == i_slot_tmr_val[g*16 +: 16]);
        assign fire[g] = i_enable && in_seq &&
                         (i_slot_trig_timer[g] ? tm_hit : st_hit);
    end

    // Pick the next pending slot: high priority first, then sequence order.
    always_comb begin
        pick_ok = 1'b0;
        pick_slot = 3'h0;
        for (int k = aes_pkg::NUM_SLOTS - 1; k >= 0; k--) begin
            if (pend_r[3'(seq_r + 3'(k))] && !i_slot_high_prio[3'(seq_r + 3'(k))]) begin
                pick_ok = 1'b1;
                pick_slot = 3'(seq_r + 3'(k));
            end
        end
        for (int k = aes_pkg::NUM_SLOTS - 1; k >= 0; k--) begin
            if (pend_r[3'(seq_r + 3'(k))] && i_slot_high_prio[3'(seq_r + 3'(k))]) begin
                pick_ok = 1'b1;
                pick_slot = 3'(seq_r + 3'(k));
            end
        end
    end

    // Issue: line requests go first, then pending slots.
    assign conv_start = !conv_busy && (line_req_r || pick_ok);
    assign start_ch = line_req_r ? aes_pkg::CH_LINE : slot_ch(i_slot_ch, pick_slot);
    assign done_ch = conv_ch;

    // Next values for scheduler state.
    always_comb begin
        pend_nxt = pend_r | fire;
        seq_nxt = seq_r;
        act_slot_nxt = act_slot_r;
        line_act_nxt = line_act_r;
        line_req_nxt = line_req_r;
        dc_cnt_nxt = dc_cnt_r;
        irq_nxt = 1'b0;
        state_q_nxt = i_event_state_machine;
        for (int c = 0; c < aes_pkg::NUM_CH; c++) begin
            res_nxt[c] = res_r[c];
        end
        // A start clears the line request before the sources are looked at, so that
        // a new line event in the same cycle is kept rather than lost.
        if (conv_start) begin
            if (line_req_r) begin
                line_req_nxt = 1'b0;
                line_act_nxt = 1'b1;
            end else begin
                line_act_nxt = 1'b0;
                act_slot_nxt = pick_slot;
                pend_nxt[pick_slot] = fire[pick_slot];
                seq_nxt = (pick_slot == i_seq_len_m1) ? 3'h0 : 3'(pick_slot + 3'h1);
            end
        end
        // Line channel sampling source.
        if (i_dc_start) begin
            if (dc_cnt_r == 32'(aes_pkg::DC_PERIOD_CYC - 1)) begin
                dc_cnt_nxt = 32'h0;
                line_req_nxt = i_enable;
            end else begin
                dc_cnt_nxt = dc_cnt_r + 32'h1;
            end
        end else begin
            dc_cnt_nxt = 32'h0;
            if (i_line_peak && i_enable) begin
                line_req_nxt = 1'b1;
            end
        end
        if (conv_done) begin
            res_nxt[done_ch] = conv_data;
            irq_nxt = !line_act_r && i_slot_irq_en[act_slot_r];
        end
        if (!i_enable) begin
            pend_nxt = 8'h00;
            line_req_nxt = 1'b0;
        end
    end

    // Registers of the scheduler.
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            pend_r <= 8'h00;
            seq_r <= 3'h0;
            state_q_r <= 3'h0;
            act_slot_r <= 3'h0;
            dc_cnt_r <= 32'h0;
            line_req_r <= 1'b0;
            line_act_r <= 1'b0;
            irq_r <= 1'b0;
            for (int c = 0; c < aes_pkg::NUM_CH; c++) begin
                res_r[c] <= 10'h000;
            end
        end else begin
            pend_r <= pend_nxt;
            seq_r <= seq_nxt;
            state_q_r <= state_q_nxt;
            act_slot_r <= act_slot_nxt;
            dc_cnt_r <= dc_cnt_nxt;
            line_req_r <= line_req_nxt;
            line_act_r <= line_act_nxt;
            irq_r <= irq_nxt;
            for (int c = 0; c < aes_pkg::NUM_CH; c++) begin
                res_r[c] <= res_nxt[c];
            end
        end
    end

    // Converter core.
    aes_converter u_conv (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .i_start(conv_start),
        .i_ch(start_ch),
        .i_adc_data(i_adc_data),
        .o_busy(conv_busy),
        .o_done(conv_done),
        .o_ch(conv_ch),
        .o_data(conv_data),
        .o_sampling(o_adc_sampling)
    );

    // Outputs; results read by the processor for its loop.
    assign o_rd_data = res_r[i_rd_ch];
    assign o_results = {res_r[3], res_r[2], res_r[1], res_r[0]};
    assign o_irq = irq_r;
    assign o_busy = conv_busy;
    assign o_adc_ch = conv_ch;

    // ==========================================================
    // Checks
    chk_irq_masked: assert property (@(posedge i_clk) disable iff (!i_nrst)
        conv_done && (line_act_r || !i_slot_irq_en[act_slot_r]) |=> !o_irq)
        else $error("interrupt raised for unselected conversion");
    chk_irq_sel: assert property (@(posedge i_clk) disable iff (!i_nrst)
        conv_done && !line_act_r && i_slot_irq_en[act_slot_r] |=> o_irq)
        else $error("selected completion gave no interrupt");
    chk_irq_pulse: assert property (@(posedge i_clk) disable iff (!i_nrst)
        o_irq |=> !o_irq)
        else $error("interrupt longer than one cycle");
    chk_result_latch: assert property (@(posedge i_clk) disable iff (!i_nrst)
        conv_done |=> res_r[$past(done_ch)] == $past(conv_data))
        else $error("result not latched");
    chk_result_hold: assert property (@(posedge i_clk) disable iff (!i_nrst)
        !conv_done |=> $stable(o_results))
        else $error("result changed without conversion");
    chk_prio_order: assert property (@(posedge i_clk) disable iff (!i_nrst)
        conv_start && !line_req_r && |(pend_r & i_slot_high_prio) |->
        i_slot_high_prio[pick_slot])
        else $error("low priority served first");
    chk_line_first: assert property (@(posedge i_clk) disable iff (!i_nrst)
        conv_start && line_req_r |=> o_adc_ch == aes_pkg::CH_LINE)
        else $error("line channel not converted");
    chk_dc_period: assert property (@(posedge i_clk) disable iff (!i_nrst)
        i_dc_start && i_enable && dc_cnt_r == 32'(aes_pkg::DC_PERIOD_CYC - 1) |=> line_req_r)
        else $error("DC period gave no line request");
    chk_dc_no_peak: assert property (@(posedge i_clk) disable iff (!i_nrst)
        i_dc_start && !line_req_r && dc_cnt_r != 32'(aes_pkg::DC_PERIOD_CYC - 1) |=>
        !line_req_r)
        else $error("line request raised between DC periods");
    // The pending bit lands one edge after the trigger, so the converter is busy two edges on.
    chk_pend_start: assert property (@(posedge i_clk) disable iff (!i_nrst)
        fire != 8'h00 && i_enable && !conv_busy && !line_req_r |-> ##2 o_busy)
        else $error("trigger did not start conversion");
    chk_seq_wrap: assert property (@(posedge i_clk) disable iff (!i_nrst)
        seq_r <= i_seq_len_m1 || $changed(i_seq_len_m1) || $past(seq_r) > i_seq_len_m1)
        else $error("sequence pointer past end");
endmodule

// file: verif/aes_adc_model.sv
// Purpose: Behavioural model of the analog core that feeds the converter.
// Assumes: The scheduler takes the result word while a conversion is busy.
// Notes: Outside a conversion the word is inverted, so a stale or early read shows up.
module aes_adc_model (
    input wire logic i_busy,
    input wire logic [1:0] i_ch,
    input wire logic [7:0] i_pattern,
    output logic [9:0] o_data
);
    timeunit 1ns;
    timeprecision 1ns;
    // ==========================================================
    // Result word
    // The selected channel and the bench pattern form the word during a conversion.
    assign o_data = i_busy ? {i_ch, i_pattern} : ~{i_ch, i_pattern};
endmodule

// file: verif/adc_event_scheduler_tb_top.sv
// Purpose: Self-checking bench of the converter event scheduler.
// Assumes: Inputs change on the falling clock edge; the clock is 10 MHz.
// Notes: The long DC period is run once; the line channel is also reached by a peak event.
module adc_event_scheduler_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {logic [1:0] ch; logic use_tmr; logic ien; logic [7:0] p;} aes_row_type;
    logic i_clk = 1'b0, i_nrst = 1'b0, i_enable = 1'b1, i_line_peak = 1'b0, i_dc_start = 1'b0;
    logic [2:0] seq_m1 = 3'h0, st = 3'h0;
    logic [15:0] slot_ch = 16'h0000, tmr = 16'h0000;
    logic [7:0] trig_t = 8'h00, prio = 8'h00, irq_en = 8'h00, pat = 8'h00;
    logic [23:0] slot_st = {8{3'h5}};
    logic [127:0] tmr_val = {8{16'h0040}};
    logic [1:0] rd_ch = 2'h0, adc_ch;
    logic [9:0] rd_data, adc_data;
    logic [39:0] results;
    logic irq, busy, samp;
    int error_cnt = 0, check_count = 0, cyc = 0, irq_n = 0, n;
    aes_row_type rows[4] = '{'{2'h1, 1'b1, 1'b1, 8'h5a}, '{2'h2, 1'b1, 1'b0, 8'ha5},
                             '{2'h3, 1'b0, 1'b1, 8'hc3}, '{2'h1, 1'b0, 1'b0, 8'h0f}};
    // ==========================================================
    // Design and far side
    aes_scheduler dut (.i_clk(i_clk), .i_nrst(i_nrst), .i_enable(i_enable),
        .i_seq_len_m1(seq_m1), .i_slot_ch(slot_ch), .i_slot_trig_timer(trig_t),
        .i_slot_state(slot_st), .i_slot_tmr_val(tmr_val), .i_slot_high_prio(prio),
        .i_slot_irq_en(irq_en), .i_event_state_machine(st), .i_timer(tmr),
        .i_line_peak(i_line_peak), .i_dc_start(i_dc_start), .i_adc_data(adc_data),
        .i_rd_ch(rd_ch), .o_rd_data(rd_data), .o_results(results), .o_irq(irq),
        .o_busy(busy), .o_adc_sampling(samp), .o_adc_ch(adc_ch));
    aes_adc_model adc (.i_busy(busy), .i_ch(adc_ch), .i_pattern(pat), .o_data(adc_data));
    // ==========================================================
    // Clock and hang guard
    // The clock toggles every half period of 50 ns.
    always #50 i_clk = ~i_clk;
    // A run past 90000 cycles, a little longer than the tests need, is cut short as a mismatch.
    always @(posedge i_clk) begin
        cyc++;
        if (cyc > 90000) begin
            error_cnt++;
            test_done();
        end
    end
    // ==========================================================
    // Tasks
    task automatic chk(input string name, input logic [39:0] exp, input logic [39:0] got);
        check_count++;
        if (exp !== got) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Waits n falling edges and counts the interrupt pulses seen.
    task automatic run(input int cycles);
        irq_n = 0;
        repeat (cycles) begin
            @(negedge i_clk);
            if (irq === 1'b1) irq_n++;
        end
    endtask
    // Presents the timer match value for exactly one cycle.
    task automatic fire_timer();
        @(negedge i_clk);
        tmr = 16'h0040;
        @(negedge i_clk);
        tmr = 16'h0000;
    endtask
    // ==========================================================
    // Main sequence
    initial begin
        repeat (8) @(negedge i_clk);
        chk("reset results", 40'h0, results);
        chk("reset irq busy", 40'h0, {38'h0, irq, busy});
        $display("reset hold test done");
        i_nrst = 1'b1;
        // Table rows: one slot, timer or state trigger, interrupt selected or not.
        foreach (rows[i]) begin
            @(negedge i_clk);
            slot_ch[1:0] = rows[i].ch;
            trig_t[0] = rows[i].use_tmr;
            irq_en[0] = rows[i].ien;
            pat = rows[i].p;
            if (rows[i].use_tmr) fire_timer();
            else st = 3'h5;
            run(70);
            st = 3'h0;
            rd_ch = rows[i].ch;
            @(negedge i_clk);
            chk("read result", {30'h0, rows[i].ch, rows[i].p}, {30'h0, rd_data});
            chk("irq count", {39'h0, rows[i].ien}, 40'(irq_n));
            $display("row %0d done", i);
        end
        chk("held channel 2", {30'h0, 2'h2, 8'ha5}, {30'h0, results[29:20]});
        chk("overwritten ch1", {30'h0, 2'h1, 8'h0f}, {30'h0, results[19:10]});
        // Two slots fire together; the high priority one is converted first.
        slot_ch[3:0] = 4'he;
        seq_m1 = 3'h1;
        trig_t[1:0] = 2'b11;
        prio[1:0] = 2'b10;
        irq_en = 8'h00;
        pat = 8'h99;
        fire_timer();
        for (n = 0; n < 10 && samp !== 1'b1; n++) @(negedge i_clk);
        chk("first channel", 40'h3, {38'h0, adc_ch});
        run(140);
        chk("both results", {20'h0, 2'h3, 8'h99, 2'h2, 8'h99}, {20'h0, results[39:20]});
        chk("unselected irq", 40'h0, 40'(irq_n));
        $display("priority test done");
        // A disabled scheduler drops its triggers.
        i_enable = 1'b0;
        fire_timer();
        run(10);
        chk("busy while off", 40'h0, {39'h0, busy});
        i_enable = 1'b1;
        $display("enable test done");
        // A line peak converts the line channel and never interrupts.
        trig_t = 8'h00;
        irq_en = 8'hff;
        pat = 8'h3c;
        i_line_peak = 1'b1;
        @(negedge i_clk);
        i_line_peak = 1'b0;
        run(70);
        chk("line result", {30'h0, 2'h0, 8'h3c}, {30'h0, results[9:0]});
        chk("line irq", 40'h0, 40'(irq_n));
        $display("line test done");
        // DC start: peaks are ignored and the line channel follows the fixed period.
        i_dc_start = 1'b1;
        i_line_peak = 1'b1;
        @(negedge i_clk);
        i_line_peak = 1'b0;
        run(10);
        chk("dc peak ignored", 40'h0, {39'h0, busy});
        run(82980);
        chk("dc before period", 40'h0, {39'h0, busy});
        run(20);
        chk("dc period busy", 40'h1, {39'h0, busy});
        chk("dc period channel", 40'h0, {38'h0, adc_ch});
        $display("dc test done");
        // A reset in mid-conversion clears the held results and the converter.
        i_nrst = 1'b0;
        i_dc_start = 1'b0;
        @(negedge i_clk);
        chk("mid reset", 40'h0, results);
        chk("mid reset irq busy", 40'h0, {38'h0, irq, busy});
        i_nrst = 1'b1;
        run(3);
        chk("after release", 40'h0, {38'h0, irq, busy});
        $display("reset test done");
        test_done();
    end
endmodule
